// ===== src/fast_serial_port.sv
// Fast serial port: register file, transmitter, receive FIFO, block receive path and interrupt.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module fast_serial_port (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic serial_tx_line,
  input wire logic serial_rx_line,
  input wire logic clear_to_send_in,
  output logic request_to_send_out,
  output logic receive_ready_flag,
  output logic irq,
  output logic mem_wr_strobe,
  output logic [15:0] mem_wr_addr,
  output logic [7:0] mem_wr_data
);

  logic [2:0] ctrl_q;
  logic [15:0] baud_divisor_value;
  logic [15:0] tx_gap_value;
  logic [3:0] irq_mask_q;
  logic [3:0] irq_st_q;
  logic [3:0] irq_ev;
  logic [15:0] blk_addr_q;
  logic tx_block;
  logic rx_block;
  logic hs_en;

  fsp_pkg::tx_state_t tx_state_q;
  logic [7:0] tx_hold_q;
  logic tx_pend_q;
  logic [7:0] tx_shreg_q;
  logic [15:0] tx_cnt_q;
  logic [2:0] tx_idx_q;
  logic [15:0] stop_left_q;
  logic tx_done_q;
  logic txd_q;
  logic rts_q;
  logic tx_wr;

  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_ferr;
  logic [7:0] fifo_mem [fsp_pkg::FIFO_DEPTH];
  logic [1:0] fifo_wp_q;
  logic [1:0] fifo_rp_q;
  logic [2:0] fifo_cnt_q;
  logic fifo_push;
  logic fifo_pop;
  logic fifo_ovf;

  assign tx_block = ctrl_q[fsp_pkg::CTRL_TX_BLOCK];
  assign rx_block = ctrl_q[fsp_pkg::CTRL_RX_BLOCK];
  assign hs_en = ctrl_q[fsp_pkg::CTRL_HS_EN];
  assign tx_wr = reg_wr && reg_addr == fsp_pkg::ADDR_TXDATA;

  // Configuration registers written by software.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= fsp_pkg::CTRL_RESET;
      baud_divisor_value <= fsp_pkg::RATE_RESET;
      tx_gap_value <= fsp_pkg::GAP_RESET; // R03
      irq_mask_q <= 4'h0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        fsp_pkg::ADDR_CTRL: ctrl_q <= reg_wdata[fsp_pkg::CTRL_W-1:0];
        fsp_pkg::ADDR_RATE: baud_divisor_value <= reg_wdata;
        fsp_pkg::ADDR_GAP: tx_gap_value <= reg_wdata;
        fsp_pkg::ADDR_IRQ_MASK: irq_mask_q <= reg_wdata[fsp_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Read data are registered, so they stand only in the cycle after the read strobe.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        fsp_pkg::ADDR_CTRL: reg_rdata <= {13'h0000, ctrl_q};
        fsp_pkg::ADDR_RATE: reg_rdata <= baud_divisor_value;
        fsp_pkg::ADDR_RXDATA: reg_rdata <= {8'h00, fifo_mem[fifo_rp_q]};
        fsp_pkg::ADDR_STATUS: reg_rdata <= {13'h0000, tx_pend_q, tx_state_q != fsp_pkg::TX_IDLE, receive_ready_flag};
        fsp_pkg::ADDR_GAP: reg_rdata <= tx_gap_value;
        fsp_pkg::ADDR_IRQ_STAT: reg_rdata <= {12'h000, irq_st_q};
        fsp_pkg::ADDR_IRQ_MASK: reg_rdata <= {12'h000, irq_mask_q};
        fsp_pkg::ADDR_BLK_ADDR: reg_rdata <= blk_addr_q;
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Transmitter. A write to the data register while a byte is already pending is ignored.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_state_q <= fsp_pkg::TX_IDLE;
      tx_hold_q <= 8'h00;
      tx_pend_q <= 1'b0;
      tx_shreg_q <= 8'h00;
      tx_cnt_q <= 16'h0000;
      tx_idx_q <= 3'h0;
      stop_left_q <= 16'h0000;
      tx_done_q <= 1'b0;
      txd_q <= 1'b1;
      rts_q <= 1'b0;
    end else begin
      tx_done_q <= 1'b0;
      if (tx_wr && !tx_pend_q) begin
        tx_hold_q <= reg_wdata[fsp_pkg::BYTE_W-1:0];
        tx_pend_q <= 1'b1;
      end
      unique case (tx_state_q)
        fsp_pkg::TX_IDLE: begin
          txd_q <= 1'b1; // R12
          tx_cnt_q <= 16'h0000;
          if (tx_pend_q) begin
            tx_shreg_q <= tx_hold_q;
            tx_pend_q <= 1'b0;
            if (hs_en) begin
              rts_q <= 1'b1;
              tx_state_q <= fsp_pkg::TX_HOLD;
            end else begin
              txd_q <= 1'b0;
              tx_state_q <= fsp_pkg::TX_START;
            end
          end
        end
        fsp_pkg::TX_HOLD: begin
          // Request-to-send is already up; the partner holds the byte off with clear-to-send low.
          if (clear_to_send_in) begin
            txd_q <= 1'b0; // R09
            tx_state_q <= fsp_pkg::TX_START;
          end
        end
        fsp_pkg::TX_START: begin
          if (fsp_pkg::bit_end(tx_cnt_q, baud_divisor_value)) begin
            tx_cnt_q <= 16'h0000;
            tx_idx_q <= 3'h0;
            txd_q <= tx_shreg_q[0]; // R12
            tx_state_q <= fsp_pkg::TX_DATA;
          end else begin
            tx_cnt_q <= tx_cnt_q + 16'h0001; // R01
          end
        end
        fsp_pkg::TX_DATA: begin
          if (fsp_pkg::bit_end(tx_cnt_q, baud_divisor_value)) begin
            tx_cnt_q <= 16'h0000;
            tx_idx_q <= tx_idx_q + 3'h1;
            if (tx_idx_q + 3'h1 == fsp_pkg::RTS_DROP_BIT) begin
              rts_q <= 1'b0; // R10
            end
            if (tx_idx_q == fsp_pkg::LAST_BIT) begin
              txd_q <= 1'b1;
              stop_left_q <= fsp_pkg::stop_bits(tx_gap_value, tx_block) - 16'h0001; // R02
              tx_state_q <= fsp_pkg::TX_STOP;
            end else begin
              txd_q <= tx_shreg_q[tx_idx_q + 3'h1]; // R01
            end
          end else begin
            tx_cnt_q <= tx_cnt_q + 16'h0001;
          end
        end
        fsp_pkg::TX_STOP: begin
          // A long gap only stretches the line-high time; the next byte may already be pending.
          if (fsp_pkg::bit_end(tx_cnt_q, baud_divisor_value)) begin
            tx_cnt_q <= 16'h0000;
            if (stop_left_q == 16'h0000) begin
              tx_done_q <= 1'b1;
              tx_state_q <= fsp_pkg::TX_IDLE;
            end else begin
              stop_left_q <= stop_left_q - 16'h0001; // R02
            end
          end else begin
            tx_cnt_q <= tx_cnt_q + 16'h0001;
          end
        end
      endcase
    end
  end

  assign serial_tx_line = txd_q;
  assign request_to_send_out = rts_q;

  fsp_receiver u_receiver (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .serial_rx_line(serial_rx_line),
    .baud_divisor_value(baud_divisor_value),
    .byte_valid(rx_valid),
    .byte_data(rx_data),
    .frame_err(rx_ferr)
  );

  // Byte-mode FIFO; a byte that arrives when it is full is dropped and flagged.
  assign fifo_push = rx_valid && !rx_block && fifo_cnt_q != fsp_pkg::FIFO_FULL; // R06
  assign fifo_ovf = rx_valid && !rx_block && fifo_cnt_q == fsp_pkg::FIFO_FULL;
  assign fifo_pop = reg_rd && reg_addr == fsp_pkg::ADDR_RXDATA && fifo_cnt_q != 3'h0;

  always_ff @(posedge clk_sys) begin
    if (fifo_push) begin
      fifo_mem[fifo_wp_q] <= rx_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fifo_wp_q <= 2'h0;
      fifo_rp_q <= 2'h0;
      fifo_cnt_q <= 3'h0;
    end else begin
      if (fifo_push) begin
        fifo_wp_q <= fifo_wp_q + 2'h1;
      end
      if (fifo_pop) begin
        fifo_rp_q <= fifo_rp_q + 2'h1;
      end
      if (fifo_push && !fifo_pop) begin
        fifo_cnt_q <= fifo_cnt_q + 3'h1;
      end else if (fifo_pop && !fifo_push) begin
        fifo_cnt_q <= fifo_cnt_q - 3'h1;
      end
    end
  end

  assign receive_ready_flag = fifo_cnt_q != 3'h0; // R06

  // Block-mode bytes go straight to memory at an auto-incrementing address.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      blk_addr_q <= fsp_pkg::BLK_ADDR_RESET;
      mem_wr_strobe <= 1'b0;
      mem_wr_addr <= 16'h0000;
      mem_wr_data <= 8'h00;
    end else begin
      mem_wr_strobe <= rx_valid && rx_block; // R07
      if (rx_valid && rx_block) begin
        mem_wr_addr <= blk_addr_q;
        mem_wr_data <= rx_data;
      end
      if (reg_wr && reg_addr == fsp_pkg::ADDR_BLK_ADDR) begin
        blk_addr_q <= reg_wdata;
      end else if (rx_valid && rx_block) begin
        blk_addr_q <= blk_addr_q + 16'h0001;
      end
    end
  end

  // Sticky events; a read clears them, but an event in the same cycle survives the clear.
  assign irq_ev = {fifo_ovf, rx_ferr, tx_done_q, rx_valid};

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_st_q <= 4'h0;
    end else if (reg_rd && reg_addr == fsp_pkg::ADDR_IRQ_STAT) begin
      irq_st_q <= irq_ev;
    end else begin
      irq_st_q <= irq_st_q | irq_ev;
    end
  end

  assign irq = |(irq_st_q & irq_mask_q);

  chk_gap_default: assert property (@(posedge clk_sys)
    $rose(rstn) |-> tx_gap_value == fsp_pkg::GAP_RESET) // R03
    else $error("Gap value does not hold its reset default.");

  chk_stop_length: assert property (@(posedge clk_sys) disable iff (!rstn)
    (tx_state_q == fsp_pkg::TX_DATA && $past(tx_state_q) == fsp_pkg::TX_DATA) ##1 tx_state_q == fsp_pkg::TX_STOP
    |-> stop_left_q == fsp_pkg::stop_bits(tx_gap_value, tx_block) - 16'h0001) // R02
    else $error("Stop interval not loaded from the gap value.");

  chk_start_low: assert property (@(posedge clk_sys) disable iff (!rstn)
    (tx_state_q == fsp_pkg::TX_START) |-> !serial_tx_line) // R12
    else $error("Start bit is not low.");

  chk_stop_high: assert property (@(posedge clk_sys) disable iff (!rstn)
    (tx_state_q == fsp_pkg::TX_STOP || tx_state_q == fsp_pkg::TX_IDLE) |-> serial_tx_line) // R12
    else $error("Line not high in stop or idle.");

  chk_data_order: assert property (@(posedge clk_sys) disable iff (!rstn)
    (tx_state_q == fsp_pkg::TX_DATA) |-> serial_tx_line == tx_shreg_q[tx_idx_q]) // R01
    else $error("Data bit out of order or inverted.");

  chk_cts_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    (tx_state_q == fsp_pkg::TX_HOLD) |=> tx_state_q == ($past(clear_to_send_in) ? fsp_pkg::TX_START : fsp_pkg::TX_HOLD)) // R09
    else $error("Held byte did not follow clear-to-send.");

  chk_rts_drop: assert property (@(posedge clk_sys) disable iff (!rstn)
    (tx_state_q == fsp_pkg::TX_DATA && tx_idx_q >= fsp_pkg::RTS_DROP_BIT) |-> !request_to_send_out) // R10
    else $error("Request-to-send still high after the third data bit began.");

  chk_rx_ready: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rx_valid && !rx_block && fifo_cnt_q != fsp_pkg::FIFO_FULL) |=> receive_ready_flag) // R06
    else $error("Receive-ready flag missing after a byte.");

  chk_block_mem: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rx_valid && rx_block) |=> mem_wr_strobe && (fifo_cnt_q <= $past(fifo_cnt_q)) && mem_wr_data == $past(rx_data)) // R07
    else $error("Block byte did not go straight to memory.");

  chk_irq_level: assert property (@(posedge clk_sys) disable iff (!rstn)
    irq_ev[fsp_pkg::IRQ_RX_BYTE] && irq_mask_q[fsp_pkg::IRQ_RX_BYTE] && !(reg_wr && reg_addr == fsp_pkg::ADDR_IRQ_MASK)
    |=> irq)
    else $error("Unmasked event did not raise the interrupt.");

endmodule

// ===== pkg/fsp_pkg.sv
// Constants, types and helpers shared by the fast serial port design.
// Overview of operation
// [R01] Every serial bit lasts one bit period set by the baud divisor, and a high line level is a one.
// [R02] In block transmit mode the stop interval after each byte lasts the gap value minus 9 bit periods.
// [R03] After reset the gap value gives a block-mode stop interval of two bit periods.
// [R04] The receiver treats its input as asynchronous and realigns its bit timing on every start edge.
// [R05] The receiver decodes correctly with up to five percent rate error when the divisor is 23 or more.
// [R06] In byte receive mode bytes enter a receive FIFO and the receive-ready flag is high while it is not empty.
// [R07] In block receive mode bytes go straight to the memory system and bypass the receive FIFO.
// [R08] With handshake on, the partner pauses the port by dropping clear-to-send 1.5 clocks before request-to-send rises.
// [R09] A held byte is sent once clear-to-send is high again, and the partner keeps it high until the start bit.
// [R10] With handshake on, request-to-send drops during the third data bit of each byte.
// [R11] The partner may keep clear-to-send high until request-to-send drops, which is always after the start bit.
// [R12] A character is one low start bit, eight data bits least significant first, and a high stop interval.
package fsp_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;

  // Register byte addresses.
  localparam logic [15:0] ADDR_CTRL = 16'hc060;
  localparam logic [15:0] ADDR_RATE = 16'hc064;
  localparam logic [15:0] ADDR_TXDATA = 16'hc068;
  localparam logic [15:0] ADDR_RXDATA = 16'hc06c;
  localparam logic [15:0] ADDR_STATUS = 16'hc070;
  localparam logic [15:0] ADDR_GAP = 16'hc074;
  localparam logic [15:0] ADDR_IRQ_STAT = 16'hc078;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'hc07c;
  localparam logic [15:0] ADDR_BLK_ADDR = 16'hc080;

  // Control register fields.
  localparam int CTRL_W = 3;
  localparam int CTRL_TX_BLOCK = 0;
  localparam int CTRL_RX_BLOCK = 1;
  localparam int CTRL_HS_EN = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Status register fields.
  localparam int ST_RX_READY = 0;
  localparam int ST_TX_BUSY = 1;
  localparam int ST_TX_PEND = 2;

  // Interrupt status and mask fields.
  localparam int IRQ_W = 4;
  localparam int IRQ_RX_BYTE = 0;
  localparam int IRQ_TX_DONE = 1;
  localparam int IRQ_FRAME_ERR = 2;
  localparam int IRQ_RX_OVF = 3;

  // Reset values and framing figures.
  localparam logic [15:0] GAP_RESET = 16'h000b;
  localparam logic [15:0] GAP_OVERHEAD = 16'h0009;
  localparam logic [15:0] RATE_RESET = 16'h0017;
  localparam logic [15:0] STOP_MIN = 16'h0001;
  localparam logic [15:0] BLK_ADDR_RESET = 16'h0000;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] RTS_DROP_BIT = 3'h2;

  // Receive FIFO geometry.
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_PTR_W = 2;
  localparam logic [2:0] FIFO_FULL = 3'h4;

  typedef enum logic [2:0] {TX_IDLE, TX_HOLD, TX_START, TX_DATA, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  // A bit period spans divisor plus one clock cycles, counted from zero.
  function automatic logic bit_end(input logic [15:0] cnt, input logic [15:0] div);
    return cnt == div;
  endfunction

  // Stop interval length in bit periods; a gap at or below the overhead falls back to one.
  function automatic logic [15:0] stop_bits(input logic [15:0] gap, input logic block);
    logic [15:0] len;
    len = STOP_MIN;
    if (block && gap > GAP_OVERHEAD) begin
      len = gap - GAP_OVERHEAD;
    end
    return len;
  endfunction

endpackage

// ===== src/fsp_receiver.sv
// Serial receiver that realigns on each start edge and delivers framed bytes.
`timescale 1ns/1ps
module fsp_receiver (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic serial_rx_line,
  input wire logic [15:0] baud_divisor_value,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic frame_err
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic fall;
  fsp_pkg::rx_state_t state_q;
  logic [15:0] cnt_q;
  logic [2:0] idx_q;
  logic [7:0] shreg_q;

  // Two-stage synchroniser; the line has no phase relation to clk_sys.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      sync1_q <= serial_rx_line; // R04
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  assign fall = prev_q & ~sync2_q;

  // Bit timing restarts at each start edge, so rate error only accumulates over one character.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= fsp_pkg::RX_IDLE;
      cnt_q <= 16'h0000;
      idx_q <= 3'h0;
      shreg_q <= 8'h00;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
      frame_err <= 1'b0;
    end else begin
      byte_valid <= 1'b0;
      frame_err <= 1'b0;
      unique case (state_q)
        fsp_pkg::RX_IDLE: begin
          cnt_q <= 16'h0000;
          if (fall) begin
            state_q <= fsp_pkg::RX_START; // R04
          end
        end
        fsp_pkg::RX_START: begin
          // Mid-bit check of the start bit; a short glitch returns to idle.
          if (fsp_pkg::bit_end(cnt_q, baud_divisor_value >> 1)) begin
            cnt_q <= 16'h0000;
            idx_q <= 3'h0;
            state_q <= sync2_q ? fsp_pkg::RX_IDLE : fsp_pkg::RX_DATA; // R12
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        fsp_pkg::RX_DATA: begin
          // Sampling at bit centres leaves half a bit of margin against rate error.
          if (fsp_pkg::bit_end(cnt_q, baud_divisor_value)) begin
            cnt_q <= 16'h0000;
            shreg_q <= {sync2_q, shreg_q[7:1]}; // R01 R05 R12
            idx_q <= idx_q + 3'h1;
            if (idx_q == fsp_pkg::LAST_BIT) begin
              state_q <= fsp_pkg::RX_STOP;
            end
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        fsp_pkg::RX_STOP: begin
          if (fsp_pkg::bit_end(cnt_q, baud_divisor_value)) begin
            byte_valid <= sync2_q;
            frame_err <= ~sync2_q; // R12
            byte_data <= shreg_q;
            state_q <= fsp_pkg::RX_IDLE;
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
      endcase
    end
  end

  chk_rx_start_edge: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == fsp_pkg::RX_IDLE && fall) |=> state_q == fsp_pkg::RX_START) // R04
    else $error("Receiver missed a start edge.");

  chk_rx_stop_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == fsp_pkg::RX_STOP && fsp_pkg::bit_end(cnt_q, baud_divisor_value)) |=> (byte_valid ^ frame_err)) // R12
    else $error("Stop bit gave neither a byte nor a framing error.");

endmodule

// ===== verification/serial_terminal_model.sv
// Behavioural serial terminal facing the fast serial port's line and handshake pins.
`timescale 1ns/1ps
module serial_terminal_model (
  input wire logic clk_sys,
  input wire logic serial_tx_line,
  output logic serial_rx_line,
  output logic clear_to_send_in
);
  // The line idles high and the terminal starts out ready to accept characters.
  initial begin
    serial_rx_line = 1'b1;
    clear_to_send_in = 1'b1;
  end

  // Sends one character on its own time base, so that the receiver cannot lean on clk_sys phase.
  task automatic send_byte(input logic [7:0] b, input realtime bt, input logic stop_lvl);
    serial_rx_line = 1'b0;
    #bt;
    for (int i = 0; i < 8; i++) begin
      serial_rx_line = b[i];
      #bt;
    end
    serial_rx_line = stop_lvl;
    #bt;
    serial_rx_line = 1'b1;
    #bt;
  endtask

  // Decodes one character by sampling each bit at its centre.
  task automatic get_byte(input realtime bt, output logic [7:0] b, output logic stop_ok);
    @(negedge serial_tx_line);
    #(bt / 2);
    for (int i = 0; i < 8; i++) begin
      #bt;
      b[i] = serial_tx_line;
    end
    #bt;
    stop_ok = serial_tx_line;
  endtask

  // Callers drop this before a byte is offered and then keep it high until request-to-send falls.
  task automatic set_cts(input logic v);
    @(posedge clk_sys);
    clear_to_send_in <= v;
  endtask
endmodule

// ===== verification/fast_serial_port_tb_top.sv
// Self-checking bench for the fast serial port: registers, transmit, receive and handshake.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module fast_serial_port_tb_top;
  localparam realtime BT = 600.0;
  logic clk_sys;
  logic rstn;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic serial_tx_line;
  logic serial_rx_line;
  logic clear_to_send_in;
  logic request_to_send_out;
  logic receive_ready_flag;
  logic irq;
  logic mem_wr_strobe;
  logic [15:0] mem_wr_addr;
  logic [7:0] mem_wr_data;
  logic [23:0] mem_q[$];
  logic [7:0] b;
  logic ok;
  int n;
  int n_fail = 0;
  int checked = 0;

  fast_serial_port fast_serial_port_i (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_tx_line(serial_tx_line), .serial_rx_line(serial_rx_line), .clear_to_send_in(clear_to_send_in),
    .request_to_send_out(request_to_send_out), .receive_ready_flag(receive_ready_flag), .irq(irq),
    .mem_wr_strobe(mem_wr_strobe), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data));

  serial_terminal_model serial_terminal_model_i (.clk_sys(clk_sys), .serial_tx_line(serial_tx_line),
    .serial_rx_line(serial_rx_line), .clear_to_send_in(clear_to_send_in));

  // 40 MHz system clock.
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Logs block-mode memory writes as address and data pairs.
  always @(posedge clk_sys) begin
    if (mem_wr_strobe === 1'b1) begin
      mem_q.push_back({mem_wr_addr, mem_wr_data});
    end
  end

  task automatic end_sim;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are sampled mid-cycle there.
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e, input string nm);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    `CHK(nm, e, reg_rdata)
  endtask

  function automatic logic probe(input int s);
    case (s)
      0: return serial_tx_line;
      1: return request_to_send_out;
      2: return irq;
      default: return receive_ready_flag;
    endcase
  endfunction

  // Counts clocks until a watched output reaches a level; a bound keeps a dead design from hanging here.
  task automatic cyc_until(input int s, input logic lvl, output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      #1;
      c++;
    end while (probe(s) !== lvl && c < 5000);
    if (c >= 5000) begin
      n_fail++;
      $display("mismatch wait %0d exp %b got timeout", s, lvl);
    end
  endtask

  // Gives up long after all tests should have ended.
  initial begin
    #500000;
    n_fail++;
    $display("mismatch watchdog exp done got timeout");
    end_sim();
  end

  // Main sequence of tests.
  initial begin
    rstn = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
    `CHK("tx idle in reset", 1'b1, serial_tx_line)
    `CHK("rts in reset", 1'b0, request_to_send_out)
    `CHK("irq in reset", 1'b0, irq)
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    reg_write(fsp_pkg::ADDR_STATUS, 16'hffff);
    rd_chk(fsp_pkg::ADDR_CTRL, 16'h0000, "ctrl");
    rd_chk(fsp_pkg::ADDR_RATE, 16'h0017, "divisor");
    rd_chk(fsp_pkg::ADDR_GAP, 16'h000b, "gap");
    rd_chk(fsp_pkg::ADDR_STATUS, 16'h0000, "status");
    rd_chk(fsp_pkg::ADDR_IRQ_MASK, 16'h0000, "mask");
    rd_chk(16'hc0fe, 16'h0000, "unmapped");
    $display("test reset done");
    reg_write(fsp_pkg::ADDR_IRQ_MASK, 16'h0007);
    fork
      serial_terminal_model_i.get_byte(BT, b, ok);
      reg_write(fsp_pkg::ADDR_TXDATA, 16'h00a5);
    join
    `CHK("tx byte", 8'ha5, b)
    `CHK("tx stop", 1'b1, ok)
    cyc_until(2, 1'b1, n);
    rd_chk(fsp_pkg::ADDR_IRQ_STAT, 16'h0002, "irq tx done");
    `CHK("irq cleared", 1'b0, irq)
    $display("test byte transmit done");
    // Zero bytes make the high run between starts exactly the stop interval plus the idle clock.
    reg_write(fsp_pkg::ADDR_CTRL, 16'h0001);
    for (int g = 0; g < 2; g++) begin
      if (g == 1) begin
        reg_write(fsp_pkg::ADDR_GAP, 16'h000c);
      end
      reg_write(fsp_pkg::ADDR_TXDATA, 16'h0000);
      reg_write(fsp_pkg::ADDR_TXDATA, 16'h0000);
      rd_chk(fsp_pkg::ADDR_STATUS, 16'h0006, "tx busy pend");
      cyc_until(0, 1'b0, n);
      cyc_until(0, 1'b1, n);
      cyc_until(0, 1'b0, n);
      `CHK("block stop gap", (g + 2) * 24 + 1, n)
      rd_chk(fsp_pkg::ADDR_IRQ_STAT, 16'h0002, "first done");
      cyc_until(2, 1'b1, n);
      rd_chk(fsp_pkg::ADDR_IRQ_STAT, 16'h0002, "second done");
    end
    $display("test block transmit done");
    serial_terminal_model_i.set_cts(1'b0);
    reg_write(fsp_pkg::ADDR_CTRL, 16'h0004);
    reg_write(fsp_pkg::ADDR_TXDATA, 16'h0096);
    repeat (100) @(posedge clk_sys);
    #1;
    `CHK("rts raised", 1'b1, request_to_send_out)
    `CHK("held by cts", 1'b1, serial_tx_line)
    fork
      serial_terminal_model_i.get_byte(BT, b, ok);
      begin
        serial_terminal_model_i.set_cts(1'b1);
        cyc_until(0, 1'b0, n);
        cyc_until(1, 1'b0, n);
        `CHK("rts drop in bit2", 1'b1, (n >= 72 && n < 96))
      end
    join
    `CHK("held byte", 8'h96, b)
    cyc_until(2, 1'b1, n);
    rd_chk(fsp_pkg::ADDR_IRQ_STAT, 16'h0002, "hs done");
    $display("test handshake done");
    reg_write(fsp_pkg::ADDR_CTRL, 16'h0000);
    serial_terminal_model_i.send_byte(8'h3c, BT, 1'b1);
    cyc_until(3, 1'b1, n);
    `CHK("irq rx", 1'b1, irq)
    serial_terminal_model_i.send_byte(8'hc3, BT * 1.05, 1'b1);
    serial_terminal_model_i.send_byte(8'h5a, BT * 0.95, 1'b1);
    rd_chk(fsp_pkg::ADDR_STATUS, 16'h0001, "rx ready");
    rd_chk(fsp_pkg::ADDR_RXDATA, 16'h003c, "rx 0");
    rd_chk(fsp_pkg::ADDR_RXDATA, 16'h00c3, "rx slow");
    rd_chk(fsp_pkg::ADDR_RXDATA, 16'h005a, "rx fast");
    `CHK("fifo empty", 1'b0, receive_ready_flag)
    rd_chk(fsp_pkg::ADDR_IRQ_STAT, 16'h0001, "irq rx byte");
    serial_terminal_model_i.send_byte(8'h55, BT, 1'b0);
    cyc_until(2, 1'b1, n);
    rd_chk(fsp_pkg::ADDR_IRQ_STAT, 16'h0004, "frame err");
    `CHK("bad byte dropped", 1'b0, receive_ready_flag)
    // A fifth unread byte finds the FIFO full, is dropped and flags an overflow.
    for (int i = 0; i < 5; i++) begin
      serial_terminal_model_i.send_byte(8'h77, BT, 1'b1);
    end
    rd_chk(fsp_pkg::ADDR_IRQ_STAT, 16'h0009, "fifo overflow");
    for (int i = 0; i < 4; i++) begin
      rd_chk(fsp_pkg::ADDR_RXDATA, 16'h0077, "rx full");
    end
    `CHK("fifo drained", 1'b0, receive_ready_flag)
    $display("test byte receive done");
    reg_write(fsp_pkg::ADDR_CTRL, 16'h0002);
    reg_write(fsp_pkg::ADDR_BLK_ADDR, 16'h0100);
    serial_terminal_model_i.send_byte(8'h11, BT, 1'b1);
    serial_terminal_model_i.send_byte(8'h22, BT, 1'b1);
    `CHK("mem writes", 2, mem_q.size())
    `CHK("mem 0", 24'h010011, mem_q[0])
    `CHK("mem 1", 24'h010122, mem_q[1])
    `CHK("fifo bypassed", 1'b0, receive_ready_flag)
    rd_chk(fsp_pkg::ADDR_BLK_ADDR, 16'h0102, "blk addr");
    $display("test block receive done");
    end_sim();
  end
endmodule
